// ---- inc/dgc_pkg.sv ----
package dgc_pkg;

  // ----------------------------------------
  // channel organisation
  // ----------------------------------------
  localparam int NUM_CH = 40;
  localparam int CH_PER_GROUP = 10;
  localparam int FIRST_SET_CH = 8;
  localparam int CH_IDX_W = 6;
  localparam int CODE_W = 14;
  localparam int GAIN_W = 13;
  localparam int FRAC_W = 13;

  typedef logic [CODE_W-1:0] dgc_code_t;
  typedef logic [GAIN_W-1:0] dgc_gain_t;
  typedef logic [CH_IDX_W-1:0] dgc_idx_t;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam dgc_code_t INPUT_RST = 14'h2000;
  localparam dgc_gain_t GAIN_RST = 13'h1FFF;
  localparam dgc_code_t OFFSET_RST = 14'h2000;
  localparam dgc_code_t CONV_RST = 14'h2000;
  localparam dgc_code_t CODE_FULL = 14'h3FFF;
  localparam dgc_code_t CODE_ZERO = 14'h0000;
  localparam logic signed [31:0] OFFSET_BIAS = 32'sh0000_2000;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [3:0] RGN_INPUT = 4'h0;
  localparam logic [3:0] RGN_GAIN = 4'h1;
  localparam logic [3:0] RGN_OFFSET = 4'h2;
  localparam logic [3:0] RGN_CONV = 4'h3;
  localparam logic [11:0] STATUS_ADDR = 12'h400;
  localparam int RGN_LSB = 8;
  localparam int IDX_LSB = 2;
  localparam int CONV_SET_BIT = 14;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SEQ_BIT = 1;
  localparam int ST_PEND_BIT = 2;
  localparam int ST_CLAMP_BIT = 3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_SEQ_US = 100;
  localparam int RST_SEQ_CYC = (RST_SEQ_US * 1000) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 13;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    dgc_code_t in_code;
    dgc_gain_t gain;
    dgc_code_t offset;
  } dgc_calc_in_s;

  typedef struct packed {
    dgc_code_t code;
    logic sat_hi;
    logic sat_lo;
  } dgc_calc_out_s;

endpackage : dgc_pkg

// ---- rtl/dgc_calc.sv ----
`timescale 1ns/1ps
module dgc_calc
  import dgc_pkg::*;
(
  input wire dgc_calc_in_s calc_in, // input, gain and offset of one channel
  output dgc_calc_out_s calc_out // clamped code and clamp flags
);

  // ----------------------------------------
  // product, scaling and offset
  // ----------------------------------------
  wire logic [CODE_W-1:0] gain_p1 = {1'b0, calc_in.gain} + 14'h0001;
  wire logic [2*CODE_W-1:0] product = calc_in.in_code * gain_p1;
  // fraction dropped before the offset is added
  wire logic signed [31:0] scaled = signed'({17'h00000, product[2*CODE_W-1:FRAC_W]});
  wire logic signed [31:0] sum = scaled + signed'({18'h0, calc_in.offset}) - OFFSET_BIAS;

  // ----------------------------------------
  // clamp
  // ----------------------------------------
  assign calc_out.sat_lo = sum[31];
  assign calc_out.sat_hi = !sum[31] && (sum[30:CODE_W] != '0);
  assign calc_out.code = calc_out.sat_lo ? CODE_ZERO :
                         calc_out.sat_hi ? CODE_FULL : sum[CODE_W-1:0];

endmodule : dgc_calc

// ---- rtl/dgc_top.sv ----
`timescale 1ns/1ps
// Contract
// - there are forty channels, four groups of ten.
// - in each group channels 0 to 7 use the first reference set and 8 and 9 the second.
// - each channel has input code, converter code, gain and offset registers.
// - the input code is 14 bits and resets to 0x2000.
// - the gain coefficient is 13 bits and resets to all ones.
// - the offset coefficient is 14 bits and resets to 0x2000.
// - the converter code is 14 bits, resets to 0x2000 and drives the converter.
// - converter code is input times (gain plus one) over 2^13 plus offset minus 2^13.
// - results above range clamp to full scale and below zero clamp to zero.
// - a channel uses only its own gain and offset.
// - after reset a sequence of about 100 us restores all defaults with busy low.
// - a write to input, gain or offset recalculates that channel, busy low meanwhile.
// - a load strobe while busy is low for a recalculation is kept and applied once busy is high again; one during the reset sequence is ignored.
module dgc_top
  import dgc_pkg::*;
#(
  parameter int RST_SEQ_CYCLES = RST_SEQ_CYC
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic load_strobe_n, // load strobe pin, active low
  output logic busy_n, // low while calculating or resetting
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_code // codes applied to the converters
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic dgc_idx_t first_set(input logic [NUM_CH-1:0] v);
    dgc_idx_t r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = dgc_idx_t'(i);
      end
    end
    return r;
  endfunction : first_set

  function automatic logic second_set(input dgc_idx_t idx);
    return (int'(idx) % CH_PER_GROUP) >= FIRST_SET_CH;
  endfunction : second_set

  // ----------------------------------------
  // state
  // ----------------------------------------
  dgc_code_t in_code_r [NUM_CH];
  dgc_gain_t gain_r [NUM_CH];
  dgc_code_t offset_r [NUM_CH];
  dgc_code_t conv_code_r [NUM_CH];
  logic [NUM_CH-1:0] dirty_r;
  logic [NUM_CH-1:0] dirty_nxt;
  logic seq_active_r;
  logic [RST_CNT_W-1:0] seq_cnt_r;
  logic ld_s1_r;
  logic ld_s2_r;
  logic pend_r;
  logic pend_nxt;
  logic clamp_r;
  logic clamp_nxt;
  logic [31:0] rdata_nxt;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic access = psel && penable && !pready;
  wire logic fire = psel && penable && pready;
  wire logic [3:0] rgn = paddr[ADDR_W-1:RGN_LSB];
  wire dgc_idx_t widx = paddr[RGN_LSB-1:IDX_LSB];
  wire logic idx_ok = int'(widx) < NUM_CH;
  wire logic is_status = paddr == STATUS_ADDR;
  wire logic is_cal = idx_ok && (rgn == RGN_INPUT || rgn == RGN_GAIN || rgn == RGN_OFFSET);
  wire logic is_conv = idx_ok && rgn == RGN_CONV;
  wire logic mapped = is_cal || is_conv || is_status;
  // writes refused during the reset sequence and to the read-only region
  wire logic bad = !mapped || (pwrite && (is_conv || seq_active_r));
  wire logic wr_cal = fire && pwrite && !bad && is_cal;
  wire logic wr_status = fire && pwrite && !bad && is_status;

  // ----------------------------------------
  // recalculation scheduling
  // ----------------------------------------
  wire logic any_dirty = |dirty_r;
  wire dgc_idx_t pick = first_set(dirty_r);
  wire logic idle = !seq_active_r && !any_dirty;
  dgc_calc_in_s calc_in;
  dgc_calc_out_s calc_out;

  assign calc_in.in_code = in_code_r[pick];
  assign calc_in.gain = gain_r[pick];
  assign calc_in.offset = offset_r[pick];

  dgc_calc u_calc (
    .calc_in(calc_in),
    .calc_out(calc_out)
  );

  always_comb begin
    dirty_nxt = dirty_r;
    if (any_dirty) begin
      dirty_nxt[pick] = 1'b0;
    end
    if (wr_cal) begin
      dirty_nxt[widx] = 1'b1;
    end
  end

  assign clamp_nxt = (clamp_r && !(wr_status && pwdata[ST_CLAMP_BIT]))
                     || (any_dirty && (calc_out.sat_hi || calc_out.sat_lo));

  // ----------------------------------------
  // load strobe
  // ----------------------------------------
  wire logic ld_low = !ld_s2_r;
  wire logic apply = pend_r && idle;
  assign pend_nxt = (ld_low && !seq_active_r) || (pend_r && !apply);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (is_status) begin
      rdata_nxt[ST_BUSY_BIT] = !busy_n;
      rdata_nxt[ST_SEQ_BIT] = seq_active_r;
      rdata_nxt[ST_PEND_BIT] = pend_r;
      rdata_nxt[ST_CLAMP_BIT] = clamp_r;
    end else if (is_cal && rgn == RGN_INPUT) begin
      rdata_nxt[CODE_W-1:0] = in_code_r[widx];
    end else if (is_cal && rgn == RGN_GAIN) begin
      rdata_nxt[GAIN_W-1:0] = gain_r[widx];
    end else if (is_cal) begin
      rdata_nxt[CODE_W-1:0] = offset_r[widx];
    end else if (is_conv) begin
      rdata_nxt[CONV_SET_BIT] = second_set(widx);
      rdata_nxt[CODE_W-1:0] = conv_code_r[widx];
    end
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && bad;
      prdata <= (access && !pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  // forty channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_code_r[i] <= INPUT_RST;
        gain_r[i] <= GAIN_RST;
        offset_r[i] <= OFFSET_RST;
        conv_code_r[i] <= CONV_RST;
        dac_code[i] <= CONV_RST;
      end
    end else begin
      if (wr_cal && rgn == RGN_INPUT) begin
        in_code_r[widx] <= pwdata[CODE_W-1:0];
      end
      if (wr_cal && rgn == RGN_GAIN) begin
        gain_r[widx] <= pwdata[GAIN_W-1:0];
      end
      if (wr_cal && rgn == RGN_OFFSET) begin
        offset_r[widx] <= pwdata[CODE_W-1:0];
      end
      if (any_dirty) begin
        conv_code_r[pick] <= calc_out.code;
      end
      if (apply) begin
        for (int i = 0; i < NUM_CH; i++) begin
          dac_code[i] <= conv_code_r[i];
        end
      end
    end
  end

  // ----------------------------------------
  // control and status
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dirty_r <= '0;
      pend_r <= 1'b0;
      clamp_r <= 1'b0;
      ld_s1_r <= 1'b1;
      ld_s2_r <= 1'b1;
      busy_n <= 1'b0;
    end else begin
      dirty_r <= dirty_nxt;
      pend_r <= pend_nxt;
      clamp_r <= clamp_nxt;
      ld_s1_r <= load_strobe_n;
      ld_s2_r <= ld_s1_r;
      busy_n <= !seq_active_r && !(|dirty_nxt);
    end
  end

  // ----------------------------------------
  // reset sequence
  // ----------------------------------------
  // restore sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_active_r <= 1'b1;
      seq_cnt_r <= '0;
    end else if (seq_active_r) begin
      if (seq_cnt_r == RST_CNT_W'(RST_SEQ_CYCLES - 1)) begin
        seq_active_r <= 1'b0;
      end
      seq_cnt_r <= seq_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_waiting;
    pend_r && !idle;
  endsequence

  sequence s_ready_to_load;
    pend_r && idle;
  endsequence

  a_seq_busy_low: assert property (
    seq_active_r |=> !busy_n)
    else $error("busy high during reset sequence");

  a_seq_ends_count: assert property (
    seq_active_r && seq_cnt_r == RST_CNT_W'(RST_SEQ_CYCLES - 1) |=> !seq_active_r)
    else $error("reset sequence length wrong");

  a_write_busy_low: assert property (
    wr_cal |=> !busy_n && dirty_r[$past(widx)])
    else $error("write did not start recalculation");

  a_calc_done_busy: assert property (
    !seq_active_r && !any_dirty && !wr_cal |=> busy_n)
    else $error("busy stuck low when idle");

  a_clamp_low_zero: assert property (
    any_dirty && calc_out.sat_lo |=> conv_code_r[$past(pick)] == CODE_ZERO)
    else $error("underflow not clamped to zero");

  a_clamp_high_full: assert property (
    any_dirty && calc_out.sat_hi |=> conv_code_r[$past(pick)] == CODE_FULL)
    else $error("overflow not clamped to full scale");

  a_unity_gain_path: assert property (
    calc_in.gain == GAIN_RST && calc_in.offset == OFFSET_RST
    |-> calc_out.code == calc_in.in_code)
    else $error("default coefficients do not pass input through");

  a_other_ch_stable: assert property (
    !(any_dirty && pick == '0) |=> $stable(conv_code_r[0]))
    else $error("channel 0 changed while another was calculated");

  a_strobe_kept: assert property (
    s_waiting |=> pend_r)
    else $error("load strobe lost while busy");

  a_strobe_applied: assert property (
    s_ready_to_load |=> dac_code[NUM_CH-1] == $past(conv_code_r[NUM_CH-1]))
    else $error("pending load not applied when idle");

  a_restore_no_dirty: assert property (
    seq_active_r |-> !any_dirty)
    else $error("recalculation pending during reset sequence");

  a_restore_refuse: assert property (
    access && pwrite && seq_active_r |=> pready && pslverr)
    else $error("write during reset sequence not refused");

  a_input_write: assert property (
    wr_cal && rgn == RGN_INPUT |=> in_code_r[$past(widx)] == $past(pwdata[CODE_W-1:0]))
    else $error("input code write lost");

  a_gain_write: assert property (
    wr_cal && rgn == RGN_GAIN |=> gain_r[$past(widx)] == $past(pwdata[GAIN_W-1:0]))
    else $error("gain coefficient write lost");

  a_offset_write: assert property (
    wr_cal && rgn == RGN_OFFSET |=> offset_r[$past(widx)] == $past(pwdata[CODE_W-1:0]))
    else $error("offset coefficient write lost");

  a_conv_from_calc: assert property (
    any_dirty |=> conv_code_r[$past(pick)] == $past(calc_out.code))
    else $error("converter code not taken from calculation");

  a_ref_set_read: assert property (
    access && !pwrite && is_conv
    |=> prdata[CONV_SET_BIT] == ((int'($past(widx)) % CH_PER_GROUP) >= FIRST_SET_CH))
    else $error("reference set bit wrong");

  a_clamp_flag_set: assert property (
    any_dirty && (calc_out.sat_hi || calc_out.sat_lo) |=> clamp_r)
    else $error("clamp not flagged");

  a_dac_hold: assert property (
    !apply |=> dac_code == $past(dac_code))
    else $error("converter codes changed without a load");

endmodule : dgc_top

// ---- verification/dgc_apb_host.sv ----
`timescale 1ns/1ps
module dgc_apb_host
  import dgc_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic pready, // slave ready
  input wire logic pslverr, // slave error
  input wire logic [31:0] prdata, // read data
  output logic psel, // select
  output logic penable, // enable
  output logic pwrite, // direction
  output logic [ADDR_W-1:0] paddr, // byte address
  output logic [31:0] pwdata, // write data
  output logic hang // no answer within the bound
);
  // ----------------------------------------
  // host bus cycles
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    hang = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    hang <= (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data no longer shows the last word
    pwdata <= ~d;
  endtask : xfer
endmodule : dgc_apb_host

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import dgc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, load_strobe_n, busy_n, hang, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
  dgc_code_t exp_conv [NUM_CH];
  dgc_code_t applied [NUM_CH];
  dgc_code_t x, o;
  dgc_gain_t g;
  int n_fail, n_tests, ch, oth;

  dgc_top #(.RST_SEQ_CYCLES(8)) i_dgc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .load_strobe_n(load_strobe_n), .busy_n(busy_n),
    .dac_code(dac_code));
  dgc_apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .hang(hang));

  always #10 pclk = ~pclk;

  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  function automatic dgc_code_t exp_code(dgc_code_t xi, dgc_gain_t gi, dgc_code_t oi);
    int v;
    v = ((int'(xi) * (int'(gi) + 1)) >>> FRAC_W) + int'(oi) - 8192;
    if (v > 16383) return CODE_FULL;
    if (v < 0) return CODE_ZERO;
    return dgc_code_t'(v);
  endfunction : exp_code

  function automatic logic [31:0] conv_word(int chn, dgc_code_t code);
    logic s;
    s = (chn % CH_PER_GROUP) >= FIRST_SET_CH;
    return {17'h00000, s, code};
  endfunction : conv_word

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h00000000, rd, err);
  endtask : rdr

  task automatic wait_idle();
    int i;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 300 && busy_n !== 1'b1; i++) @(posedge pclk);
    if (busy_n !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask : wait_idle

  always @(posedge hang) begin
    n_fail++;
    give_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    load_strobe_n = 1'b1;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(64));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk(busy_n, 0, "busy during restore");
    wr(12'h000, 32'h00000123);
    chk(err, 1, "write during restore");
    wait_idle();
    for (int chn = 0; chn < NUM_CH; chn++) begin
      exp_conv[chn] = CONV_RST;
      applied[chn] = CONV_RST;
      chk(dac_code[chn], CONV_RST, "dac code reset");
      rdr(12'(4 * chn));
      chk(rd, INPUT_RST, "input reset");
      chk(err, 1'b0, "mapped read accepted");
      rdr(12'h100 + 12'(4 * chn));
      chk(rd, GAIN_RST, "gain reset");
      rdr(12'h200 + 12'(4 * chn));
      chk(rd, OFFSET_RST, "offset reset");
      rdr(12'h300 + 12'(4 * chn));
      chk(rd, conv_word(chn, CONV_RST), "conv reset and set");
    end
    $display("test reset done");
    for (int i = 0; i < 34; i++) begin
      ch = $urandom_range(39, 1);
      x = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : (i == 2) ? 14'h1FFF : 14'($urandom);
      g = (i < 2) ? 13'h1FFF : (i == 2) ? 13'h0000 : 13'($urandom);
      o = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : (i == 2) ? 14'h2000 : 14'($urandom);
      wr(12'(4 * ch), {18'h00000, x});
      wr(12'h100 + 12'(4 * ch), {19'h00000, g});
      wr(12'h200 + 12'(4 * ch), {18'h00000, o});
      chk(err, 1'b0, "calibration write accepted");
      wait_idle();
      exp_conv[ch] = exp_code(x, g, o);
      rdr(12'h300 + 12'(4 * ch));
      chk(rd, conv_word(ch, exp_conv[ch]), "conv result");
      rdr(12'h300);
      chk(rd, conv_word(0, CONV_RST), "untouched channel");
      oth = (ch % 39) + 1;
      rdr(12'h300 + 12'(4 * oth));
      chk(rd, conv_word(oth, exp_conv[oth]), "other channel kept");
      chk(dac_code[ch], applied[ch], "no load without strobe");
    end
    $display("test calc done");
    load_strobe_n <= 1'b0;
    wr(12'h000, 32'h00001000);
    exp_conv[0] = exp_code(14'h1000, GAIN_RST, OFFSET_RST);
    wait_idle();
    repeat (6) @(posedge pclk);
    for (int chn = 0; chn < NUM_CH; chn++) begin
      chk(dac_code[chn], exp_conv[chn], "load while busy");
      applied[chn] = exp_conv[chn];
    end
    load_strobe_n <= 1'b1;
    $display("test load done");
    rdr(12'h500);
    chk(err, 1, "unmapped read");
    chk(rd, 32'h00000000, "unmapped read data");
    rdr(12'h0A0);
    chk(err, 1, "channel index 40 refused");
    wr(12'h300, 32'h00000000);
    chk(err, 1, "read only write");
    rdr(12'h300);
    chk(rd, conv_word(0, exp_conv[0]), "read only kept");
    $display("test refuse done");
    rdr(12'h400);
    chk(rd, 32'h00000001 << ST_CLAMP_BIT, "clamp seen in status");
    wr(12'h400, 32'h00000001 << ST_CLAMP_BIT);
    rdr(12'h400);
    chk(rd, 32'h00000000, "clamp flag cleared");
    $display("test status done");
    exp_conv[0] = exp_code(14'h0800, GAIN_RST, OFFSET_RST);
    fork
      wr(12'h000, 32'h00000800);
      begin
        @(posedge pclk);
        load_strobe_n <= 1'b0;
        @(posedge pclk);
        load_strobe_n <= 1'b1;
      end
    join
    wait_idle();
    repeat (4) @(posedge pclk);
    chk(dac_code[0], exp_conv[0], "short strobe kept while busy");
    chk(dac_code[ch], applied[ch], "other channel after short strobe");
    $display("test pulse done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk(busy_n, 0, "busy during second restore");
    chk(dac_code[0], CONV_RST, "dac code after second reset");
    wait_idle();
    rdr(12'h000);
    chk(rd, INPUT_RST, "input after second reset");
    rdr(12'h100 + 12'(4 * ch));
    chk(rd, GAIN_RST, "gain after second reset");
    rdr(12'h200 + 12'(4 * ch));
    chk(rd, OFFSET_RST, "offset after second reset");
    rdr(12'h300);
    chk(rd, conv_word(0, CONV_RST), "conv after second reset");
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb
